// ==== inc/spm_pkg.sv ====
/*
 * Constants, field positions and types for the secondary bus power
 * management register bank.
 * Assumes a byte-wide configuration access port inside the bridge.
 */
package spm_pkg;

	// ==========================================================
	// Register offsets (byte addresses in configuration space)
	localparam logic [7:0] SPM_OFF_CAP_LO = 8'he2;
	localparam logic [7:0] SPM_OFF_CAP_HI = 8'he3;
	localparam logic [7:0] SPM_OFF_PCS_LO = 8'he4;
	localparam logic [7:0] SPM_OFF_PCS_HI = 8'he5;
	localparam logic [7:0] SPM_OFF_BPE = 8'he6;
	localparam logic [7:0] SPM_OFF_DATA = 8'he7;
	localparam logic [7:0] SPM_OFF_RSV_FIRST = 8'he8;
	localparam logic [7:0] SPM_OFF_UNLOCK = 8'h90;
	localparam int SPM_UNLOCK_BIT = 5;

	// ==========================================================
	// Field positions
	localparam int SPM_CAP_CLK_BIT = 3;
	localparam int SPM_CAP_WAKE_LSB = 11;
	localparam int SPM_PCS_STATUS_BIT = 15;
	localparam int SPM_PCS_SCALE_LSB = 13;
	localparam int SPM_PCS_SEL_LSB = 9;
	localparam int SPM_PCS_EN_BIT = 8;
	localparam int SPM_BPE_ENABLE_BIT = 7;
	localparam int SPM_BPE_B2B3_BIT = 6;

	// ==========================================================
	// Reset values
	localparam logic [2:0] SPM_VERSION_RST = 3'h1;
	localparam logic [4:0] SPM_WAKE_CAP_RST = 5'h00;
	localparam logic [1:0] SPM_SCALE_RST = 2'h0;
	localparam logic [3:0] SPM_SEL_RST = 4'h0;
	localparam logic [7:0] SPM_BPE_RST = 8'h00;
	localparam logic [7:0] SPM_DATA_RST = 8'h00;
	localparam logic [7:0] SPM_RSV_VALUE = 8'h00;

	typedef enum logic [1:0] {
		SPM_D0 = 2'h0,
		SPM_D1 = 2'h1,
		SPM_D2 = 2'h2,
		SPM_D3HOT = 2'h3
	} spm_pstate_t;

	// Secondary bus condition: B0 full on, B2 clock stopped, B3 power off
	typedef struct packed {
		logic bus_power_off;
		logic bus_clock_stop;
	} spm_bus_ctl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spm_cfg_req_t;

endpackage

// ==== src/spm_regs.sv ====
/*
 * Power management register bank for the fast secondary bus of a host
 * bridge: capabilities, control/status, bridge extension and data.
 * Assumes a byte-wide configuration port, single-cycle reads, and the
 * unlock bit (bit 5 of index 90h) supplied as an input from elsewhere.
 */
module spm_regs
	import spm_pkg::*;
#(
	parameter logic WAKE_NO_CLOCK = 1'b0,
	parameter logic D1_SUPPORTED = 1'b0,
	parameter logic D2_SUPPORTED = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire spm_cfg_req_t cfg_req,
	output logic [7:0] cfg_rdata,
	output logic cfg_hit,
	input wire logic unlock_reg_bit,
	input wire logic wake_event,
	input wire logic [7:0] data_in,
	output logic [3:0] data_select,
	output logic wake_request_n,
	output spm_pstate_t power_state,
	output spm_bus_ctl_t bus_ctl
);

	// ==========================================================
	// State
	logic [4:0] wake_capable_states;
	logic wake_clock_free;
	logic [2:0] version;
	logic wake_event_pending;
	logic wake_event_enable;
	logic [1:0] data_scale;
	logic [7:0] bridge_power_extensions;
	logic [7:0] power_data_value;
	logic [7:0] read_mux;

	// ==========================================================
	// Decode
	wire unlocked = unlock_reg_bit;
	wire wr_cap_lo = cfg_req.wr && cfg_req.addr == SPM_OFF_CAP_LO && unlocked;
	wire wr_cap_hi = cfg_req.wr && cfg_req.addr == SPM_OFF_CAP_HI && unlocked;
	wire wr_pcs_lo = cfg_req.wr && cfg_req.addr == SPM_OFF_PCS_LO;
	wire wr_pcs_hi = cfg_req.wr && cfg_req.addr == SPM_OFF_PCS_HI;
	wire wr_bpe = cfg_req.wr && cfg_req.addr == SPM_OFF_BPE && unlocked;
	wire wr_data = cfg_req.wr && cfg_req.addr == SPM_OFF_DATA && unlocked;
	wire [1:0] req_state = cfg_req.wdata[1:0];
	// Only D0, D3hot and the optional states that are supported are taken
	wire state_ok = (req_state == SPM_D0) || (req_state == SPM_D3HOT) ||
		(req_state == SPM_D1 && D1_SUPPORTED) || (req_state == SPM_D2 && D2_SUPPORTED);
	wire clear_status = wr_pcs_hi && cfg_req.wdata[SPM_PCS_STATUS_BIT - 8];
	wire bus_ctl_en = bridge_power_extensions[SPM_BPE_ENABLE_BIT];
	wire in_d3hot = power_state == SPM_D3HOT;

	// ==========================================================
	// Capabilities (locked)
	always_ff @(posedge clk) begin
		if (reset) begin
			wake_capable_states <= SPM_WAKE_CAP_RST;
			wake_clock_free <= WAKE_NO_CLOCK;
			version <= SPM_VERSION_RST;
		end else begin
			if (wr_cap_hi) begin
				wake_capable_states <= cfg_req.wdata[7:3];
			end
			if (wr_cap_lo) begin
				wake_clock_free <= cfg_req.wdata[SPM_CAP_CLK_BIT];
				version <= cfg_req.wdata[2:0];
			end
		end
	end

	// ==========================================================
	// Control and status
	always_ff @(posedge clk) begin
		if (reset) begin
			power_state <= SPM_D0;
			wake_event_enable <= 1'b0;
			data_select <= SPM_SEL_RST;
			data_scale <= SPM_SCALE_RST;
		end else begin
			if (wr_pcs_lo && state_ok) begin
				power_state <= spm_pstate_t'(req_state);
			end
			if (wr_pcs_hi) begin
				wake_event_enable <= cfg_req.wdata[SPM_PCS_EN_BIT - 8];
				data_select <= cfg_req.wdata[4:1];
				if (unlocked) begin
					data_scale <= cfg_req.wdata[6:5];
				end
			end
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			wake_event_pending <= 1'b0;
		end else if (wake_event) begin
			wake_event_pending <= 1'b1;
		end else if (clear_status) begin
			wake_event_pending <= 1'b0;
		end
	end

	// ==========================================================
	// Bridge extension and data
	always_ff @(posedge clk) begin
		if (reset) begin
			bridge_power_extensions <= SPM_BPE_RST;
			power_data_value <= SPM_DATA_RST;
		end else begin
			if (wr_bpe) begin
				bridge_power_extensions <= {cfg_req.wdata[7:6], 6'h00};
			end
			if (wr_data) begin
				power_data_value <= cfg_req.wdata;
			end else begin
				power_data_value <= data_in;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign wake_request_n = ~(wake_event_pending & wake_event_enable);

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_ctl <= '0;
		end else if (bus_ctl_en && in_d3hot) begin
			bus_ctl.bus_power_off <= ~bridge_power_extensions[SPM_BPE_B2B3_BIT];
			bus_ctl.bus_clock_stop <= bridge_power_extensions[SPM_BPE_B2B3_BIT];
		end else begin
			bus_ctl <= '0;
		end
	end

	// ==========================================================
	// Read path
	always_comb begin
		read_mux = SPM_RSV_VALUE;
		case (cfg_req.addr)
			SPM_OFF_CAP_LO: read_mux = {4'h0, wake_clock_free, version};
			SPM_OFF_CAP_HI: read_mux = {wake_capable_states, 1'b0, D2_SUPPORTED, D1_SUPPORTED};
			SPM_OFF_PCS_LO: read_mux = {6'h00, power_state};
			SPM_OFF_PCS_HI: read_mux = {wake_event_pending, data_scale, data_select, wake_event_enable};
			SPM_OFF_BPE: read_mux = bridge_power_extensions;
			SPM_OFF_DATA: read_mux = power_data_value;
			default: read_mux = SPM_RSV_VALUE;
		endcase
	end

	assign cfg_hit = cfg_req.addr >= SPM_OFF_CAP_LO;

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rdata <= SPM_RSV_VALUE;
		end else if (cfg_req.rd) begin
			cfg_rdata <= read_mux;
		end
	end

endmodule

// ==== tb/spm_regs_monitor.sv ====
/* Port checker for the power management register bank.
   Assumes the bank is bound with its D1 and D2 support left off. */
module spm_regs_monitor
	import spm_pkg::*;
#(
	parameter logic WAKE_NO_CLOCK = 1'b0
) (
	input wire logic clk,
	input wire logic reset,
	input wire spm_cfg_req_t cfg_req,
	input wire logic [7:0] cfg_rdata,
	input wire logic cfg_hit,
	input wire logic unlock_reg_bit,
	input wire logic wake_event,
	input wire logic [7:0] data_in,
	input wire logic [3:0] data_select,
	input wire logic wake_request_n,
	input wire spm_pstate_t power_state,
	input wire spm_bus_ctl_t bus_ctl
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_RST: assert property ($fell(reset) |-> power_state == SPM_D0 && bus_ctl == 2'h0 && wake_request_n)
		else $error("state not cleared by reset");
	AST_RSV_READ: assert property (cfg_req.rd && cfg_req.addr >= SPM_OFF_RSV_FIRST |=> cfg_rdata == 8'h00)
		else $error("reserved byte not zero");
	AST_CAP_READ: assert property (cfg_req.rd && cfg_req.addr == SPM_OFF_CAP_LO |=> cfg_rdata[3:0] == {WAKE_NO_CLOCK, 3'h1})
		else $error("capability low byte wrong");
	AST_PCS_LO: assert property (cfg_req.rd && cfg_req.addr == SPM_OFF_PCS_LO |=> cfg_rdata == {6'h00, $past(power_state)})
		else $error("state byte wrong");
	AST_SEL_READ: assert property (cfg_req.rd && cfg_req.addr == SPM_OFF_PCS_HI |=> cfg_rdata[4:1] == $past(data_select))
		else $error("select readback wrong");
	AST_UNSUP: assert property (cfg_req.wr && cfg_req.addr == SPM_OFF_PCS_LO && ^cfg_req.wdata[1:0] |=> $stable(power_state))
		else $error("unsupported state taken");
	AST_BUS_IDLE: assert property ($past(power_state) != SPM_D3HOT |-> bus_ctl == 2'h0)
		else $error("bus control outside D3hot");
	AST_BUS_ONE: assert property (!(bus_ctl.bus_power_off && bus_ctl.bus_clock_stop))
		else $error("both bus actions at once");
	AST_CLEAR: assert property (cfg_req.wr && cfg_req.addr == SPM_OFF_PCS_HI && cfg_req.wdata[7] && !wake_event |=> wake_request_n)
		else $error("wake request not released");
endmodule
bind spm_regs spm_regs_monitor #(.WAKE_NO_CLOCK(WAKE_NO_CLOCK)) u_mon (.clk(clk), .reset(reset), .cfg_req(cfg_req),
	.cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .unlock_reg_bit(unlock_reg_bit), .wake_event(wake_event), .data_in(data_in),
	.data_select(data_select), .wake_request_n(wake_request_n), .power_state(power_state), .bus_ctl(bus_ctl));

// ==== tb/tb_top.sv ====
/* Self-checking bench for the power management register bank.
   Assumes default design parameters and one byte access every two cycles. */
module tb_top
	import spm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, unlock_reg_bit = 0, wake_event = 0, cfg_hit, wake_request_n, rd_hit;
	logic [7:0] data_in = 8'h00, cfg_rdata, rd_val, a;
	logic [7:0] ext_tab [3] = '{8'h00, 8'h80, 8'hc0};
	logic [3:0] data_select, sel;
	logic [1:0] cur = 2'h0;
	spm_cfg_req_t cfg_req = '0;
	spm_pstate_t power_state;
	spm_bus_ctl_t bus_ctl;
	int bad_count = 0, n_checks = 0, cycles = 0;
	spm_regs u_dut (.clk(clk), .reset(reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
		.unlock_reg_bit(unlock_reg_bit), .wake_event(wake_event), .data_in(data_in), .data_select(data_select),
		.wake_request_n(wake_request_n), .power_state(power_state), .bus_ctl(bus_ctl));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One byte access; read data is taken after the answering edge
	task automatic acc(logic w, logic [7:0] ad, logic [7:0] wd);
		@(negedge clk);
		cfg_req = '{wr: w, rd: !w, addr: ad, wdata: wd};
		rd_hit = cfg_hit;
		@(negedge clk);
		cfg_req = '0;
		rd_val = cfg_rdata;
	endtask
	function automatic logic [1:0] exp_bus(logic [1:0] s, logic [7:0] ext);
		return (ext[7] && s == 2'h3) ? (ext[6] ? 2'b01 : 2'b10) : 2'b00;
	endfunction
	initial begin
		void'($urandom(32'h1c07));
		repeat (8) @(negedge clk);
		reset = 0;
		for (int i = 0; i < 6; i++) begin
			acc(0, 8'he2 + 8'(i), 8'h00);
			chk("reset_value", rd_val, i == 0 ? 8'h01 : 8'h00);
		end
		acc(0, 8'h40, 8'h00);
		chk("unmapped", rd_val, 8'h00);
		chk("hit_low", 8'(rd_hit), 8'h00);
		wake_event = 1;
		@(negedge clk);
		wake_event = 0;
		chk("req_off", 8'(wake_request_n), 8'h01);
		acc(1, 8'he5, 8'h01);
		chk("req_on", 8'(wake_request_n), 8'h00);
		acc(1, 8'he5, 8'h81);
		chk("req_clr", 8'(wake_request_n), 8'h01);
		acc(1, 8'he6, 8'hff);
		acc(1, 8'he5, 8'h61);
		acc(0, 8'he6, 8'h00);
		chk("ext_locked", rd_val, 8'h00);
		acc(0, 8'he5, 8'h00);
		chk("scale_locked", rd_val, 8'h01);
		unlock_reg_bit = 1;
		acc(1, 8'he5, 8'h61);
		acc(0, 8'he5, 8'h00);
		chk("scale_open", rd_val, 8'h61);
		for (int j = 0; j < 3; j++) begin
			acc(1, 8'he6, ext_tab[j] | (8'($urandom) & 8'h3f));
			acc(0, 8'he6, 8'h00);
			chk("ext", rd_val, ext_tab[j]);
			for (int s = 0; s < 4; s++) begin
				acc(1, 8'he4, 8'(s) | (8'($urandom) & 8'hfc));
				cur = (s == 1 || s == 2) ? cur : 2'(s);
				acc(0, 8'he4, 8'h00);
				chk("state", rd_val, {6'h00, cur});
				chk("bus", 8'(bus_ctl), 8'(exp_bus(cur, ext_tab[j])));
			end
		end
		repeat (4) begin
			sel = 4'($urandom);
			data_in = 8'($urandom);
			acc(1, 8'he5, {3'h0, sel, 1'b0});
			acc(0, 8'he7, 8'h00);
			chk("select", 8'(data_select), 8'(sel));
			chk("data", rd_val, data_in);
			a = 8'he8 | 8'($urandom);
			acc(1, a, 8'hff);
			acc(0, a, 8'h00);
			chk("reserved", rd_val, 8'h00);
			chk("hit_rsv", 8'(rd_hit), 8'h01);
		end
		tally_and_finish();
	end
endmodule
